/* rtl/dmaeds_pkg.sv */
// Package: register map, field layout and types of the DMA error and debug status block
package dmaeds_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [11:0] DMAEDS_OFS_ACK_DELAY   = 12'h800;
    localparam logic [11:0] DMAEDS_OFS_ERR_ADDR    = 12'h900;
    localparam logic [11:0] DMAEDS_OFS_ERR_CHAN    = 12'h904;
    localparam logic [11:0] DMAEDS_OFS_DBG_ADDR    = 12'h908;
    localparam logic [11:0] DMAEDS_OFS_DBG_REQLEN  = 12'h90c;
    localparam logic [11:0] DMAEDS_OFS_DBG_STATE   = 12'h910;
    localparam logic [11:0] DMAEDS_OFS_DBG_SRC     = 12'h914;
    localparam logic [11:0] DMAEDS_OFS_DBG_TRG     = 12'h918;
    localparam logic [11:0] DMAEDS_OFS_DBG_CFG     = 12'h91c;
    localparam logic [11:0] DMAEDS_OFS_DBG_DPATH   = 12'h920;
    localparam logic [11:0] DMAEDS_OFS_DBG_MASTER  = 12'h924;
    localparam logic [11:0] DMAEDS_OFS_IRQ_STATUS  = 12'ha00;
    localparam logic [11:0] DMAEDS_OFS_IRQ_MASK    = 12'ha04;

    // ****************************************
    // Widths and reset values
    // ****************************************
    localparam int          DMAEDS_DELAY_W     = 10;
    localparam logic [9:0]  DMAEDS_DELAY_RST   = 10'h00c;
    localparam int          DMAEDS_LEN_W       = 13;
    localparam int          DMAEDS_CHAN_W      = 5;
    localparam int          DMAEDS_IRQ_W       = 2;
    localparam int          DMAEDS_IRQ_ERR     = 0;
    localparam int          DMAEDS_IRQ_ACK     = 1;
    localparam logic [1:0]  DMAEDS_HRESP_ERROR = 2'h1;

    // Transfer type codes
    localparam logic [1:0]  DMAEDS_TT_MEMORY_TO_MEMORY     = 2'h0;
    localparam logic [1:0]  DMAEDS_TT_MEMORY_TO_PERIPHERAL = 2'h1;
    localparam logic [1:0]  DMAEDS_TT_PERIPHERAL_TO_MEMORY = 2'h2;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic                     req_valid;
        logic [DMAEDS_LEN_W-1:0]  rest_len;
        logic [DMAEDS_CHAN_W-1:0] chan_num;
        logic [3:0]               chan_state;
        logic [31:0]              src_addr;
        logic [31:0]              trg_addr;
        logic                     chan_en;
        logic                     inc_src;
        logic                     inc_trg;
        logic [DMAEDS_LEN_W-1:0]  ctrl_len;
        logic [1:0]               burst_size;
        logic [1:0]               tran_type;
        logic [1:0]               item_width;
        logic [31:0]              diag_addr;
    } dmaeds_chan_type;

    typedef struct packed {
        logic       mas_read;
        logic       mas_write;
        logic [1:0] size;
        logic [1:0] burst;
        logic [6:0] slice_cnt;
        logic       split_word;
        logic       split_half;
    } dmaeds_dpath_type;

    typedef struct packed {
        logic [2:0] hburst;
        logic [1:0] htrans;
        logic [2:0] hsize;
        logic       hready;
        logic [1:0] hresp;
        logic [31:0] haddr;
    } dmaeds_ahb_type;

    // Maximum burst items for a burst size code
    function automatic logic [4:0] dmaeds_burst_items(input logic [1:0] code);
        logic [4:0] items;
        items = 5'h01;
        unique case (code)
            2'h0: items = 5'h01;
            2'h1: items = 5'h04;
            2'h2: items = 5'h08;
            2'h3: items = 5'h10;
        endcase
        return items;
    endfunction

endpackage

/* rtl/dmaeds_top.sv */
// Top: DMA error capture, debug snapshots and peripheral write acknowledge delay
// How it works
// [RULE1] Each single peripheral write is acknowledged after a programmable delay, reset twelve.
// [RULE2] Error address register holds the failing address, zero after reset.
// [RULE3] Error channel number sits in bits 31:27 of second error register.
// [RULE4] Debug address word is readable, zero after reset.
// [RULE5] Bit 31 of request register shows a valid pending request.
// [RULE6] Bits 30:18 show remaining length of selected channel.
// [RULE7] Bits 4:0 show the channel in service.
// [RULE8] Channel state appears as four bits at 31:28.
// [RULE9] Source address shown as bits 31:2 and 1:0.
// [RULE10] Target address shown as bits 31:2 and 1:0.
// [RULE11] Enable, source and target increment flags mirrored at bits 31, 30, 29.
// [RULE12] Length, burst size, type and width mirrored, width at 11:10.
// [RULE13] Datapath read, write, size, burst, slice count and split flags exposed.
// [RULE14] Bus master burst, trans, size, ready and response exposed.
// [RULE15] Software writes zero to reserved bits and ignores them on reads.
// [RULE16] Type code: 0 memory-memory, 1 memory-peripheral, 2 peripheral-memory.
// [RULE17] Burst size code selects 1, 4, 8 or 16 items.
// [RULE18] Error address and channel load together on bus error, held until next.
// [RULE19] Diagnostic fields follow the channel in service every cycle.
`timescale 1ns/1ps
module dmaeds_top
    import dmaeds_pkg::*;
(
    input  wire logic             i_ref_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_psel,
    input  wire logic             i_penable,
    input  wire logic             i_pwrite,
    input  wire logic [11:0]      i_paddr,
    input  wire logic [31:0]      i_pwdata,
    output logic      [31:0]      o_prdata,
    output logic                  o_pready,
    output logic                  o_pslverr,
    input  wire dmaeds_chan_type  i_chan,
    input  wire dmaeds_dpath_type i_dpath,
    input  wire dmaeds_ahb_type   i_ahb,
    input  wire logic             i_periph_wr_req,
    output logic                  o_periph_wr_ack,
    output logic                  o_ack_busy,
    output logic [4:0]            o_burst_items,
    output logic                  o_irq
);

    default clocking dmaeds_cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);

    // ****************************************
    // APB decode
    // ****************************************
    logic                         wr_en;
    logic                         rd_en;
    logic                         known;
    logic [DMAEDS_DELAY_W-1:0]    ack_delay_r;
    logic [31:0]                  err_addr_r;
    logic [DMAEDS_CHAN_W-1:0]     err_chan_r;
    logic [DMAEDS_IRQ_W-1:0]      irq_stat_r;
    logic [DMAEDS_IRQ_W-1:0]      irq_mask_r;
    logic [DMAEDS_IRQ_W-1:0]      irq_event;
    logic                         bus_err;
    dmaeds_chan_type              chan_r;
    dmaeds_dpath_type             dpath_r;
    dmaeds_ahb_type               ahb_r;

    function automatic logic is_known(input logic [11:0] a);
        return a == DMAEDS_OFS_ACK_DELAY  || a == DMAEDS_OFS_ERR_ADDR
            || a == DMAEDS_OFS_ERR_CHAN   || a == DMAEDS_OFS_DBG_ADDR
            || a == DMAEDS_OFS_DBG_REQLEN || a == DMAEDS_OFS_DBG_STATE
            || a == DMAEDS_OFS_DBG_SRC    || a == DMAEDS_OFS_DBG_TRG
            || a == DMAEDS_OFS_DBG_CFG    || a == DMAEDS_OFS_DBG_DPATH
            || a == DMAEDS_OFS_DBG_MASTER || a == DMAEDS_OFS_IRQ_STATUS
            || a == DMAEDS_OFS_IRQ_MASK;
    endfunction

    assign known     = is_known(i_paddr);
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel && i_penable && !known;
    assign wr_en     = i_psel && i_penable && i_pwrite && known;
    assign rd_en     = i_psel && !i_penable && !i_pwrite;

    // ****************************************
    // Acknowledge delay register
    // ****************************************
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ack_delay_r <= DMAEDS_DELAY_RST; // [RULE1]
        end else if (wr_en && i_paddr == DMAEDS_OFS_ACK_DELAY) begin
            ack_delay_r <= i_pwdata[DMAEDS_DELAY_W-1:0];
        end
    end

    // ****************************************
    // Peripheral write acknowledge delay
    // ****************************************
    typedef enum logic [1:0] {ACK_IDLE, ACK_WAIT, ACK_DONE} dmaeds_ack_type;
    dmaeds_ack_type               ack_state_r;
    logic [DMAEDS_DELAY_W-1:0]    ack_cnt_r;

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ack_state_r <= ACK_IDLE;
            ack_cnt_r   <= '0;
        end else begin
            unique case (ack_state_r)
                ACK_IDLE: begin
                    if (i_periph_wr_req) begin
                        ack_cnt_r   <= ack_delay_r; // [RULE1]
                        ack_state_r <= (ack_delay_r == '0) ? ACK_DONE : ACK_WAIT;
                    end
                end
                ACK_WAIT: begin
                    ack_cnt_r <= ack_cnt_r - 1'b1;
                    if (ack_cnt_r == 10'h001) begin
                        ack_state_r <= ACK_DONE; // [RULE1]
                    end
                end
                ACK_DONE: begin
                    ack_state_r <= ACK_IDLE;
                end
            endcase
        end
    end

    assign o_periph_wr_ack = (ack_state_r == ACK_DONE);
    assign o_ack_busy      = (ack_state_r != ACK_IDLE);

    // ****************************************
    // Live snapshots
    // ****************************************
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            chan_r  <= '0;
            dpath_r <= '0;
            ahb_r   <= '0;
        end else begin
            chan_r  <= i_chan;  // [RULE19]
            dpath_r <= i_dpath; // [RULE13]
            ahb_r   <= i_ahb;   // [RULE14]
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_burst_items <= 5'h01;
        end else begin
            o_burst_items <= dmaeds_burst_items(chan_r.burst_size); // [RULE17]
        end
    end

    // ****************************************
    // Error capture
    // ****************************************
    assign bus_err = ahb_r.hresp == DMAEDS_HRESP_ERROR && ahb_r.htrans != 2'h0;

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            err_addr_r <= '0;
            err_chan_r <= '0;
        end else if (bus_err) begin
            err_addr_r <= ahb_r.haddr;     // [RULE2] [RULE18]
            err_chan_r <= chan_r.chan_num; // [RULE3] [RULE18]
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    always_comb begin
        irq_event                 = '0;
        irq_event[DMAEDS_IRQ_ERR] = bus_err;
        irq_event[DMAEDS_IRQ_ACK] = o_periph_wr_ack;
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_stat_r <= '0;
        end else if (wr_en && i_paddr == DMAEDS_OFS_IRQ_STATUS) begin
            irq_stat_r <= (irq_stat_r & ~i_pwdata[DMAEDS_IRQ_W-1:0]) | irq_event;
        end else begin
            irq_stat_r <= irq_stat_r | irq_event;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_mask_r <= '0;
        end else if (wr_en && i_paddr == DMAEDS_OFS_IRQ_MASK) begin
            irq_mask_r <= i_pwdata[DMAEDS_IRQ_W-1:0];
        end
    end

    assign o_irq = |(irq_stat_r & irq_mask_r);

    // ****************************************
    // Read data
    // ****************************************
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_prdata <= '0;
        end else if (rd_en) begin
            o_prdata <= '0;
            unique case (i_paddr)
                DMAEDS_OFS_ACK_DELAY:  o_prdata[9:0]   <= ack_delay_r;
                DMAEDS_OFS_ERR_ADDR:   o_prdata        <= err_addr_r;     // [RULE2]
                DMAEDS_OFS_ERR_CHAN:   o_prdata[31:27] <= err_chan_r;     // [RULE3]
                DMAEDS_OFS_DBG_ADDR:   o_prdata        <= chan_r.diag_addr; // [RULE4]
                DMAEDS_OFS_DBG_REQLEN: begin
                    o_prdata[31]    <= chan_r.req_valid; // [RULE5]
                    o_prdata[30:18] <= chan_r.rest_len;  // [RULE6]
                    o_prdata[4:0]   <= chan_r.chan_num;  // [RULE7]
                end
                DMAEDS_OFS_DBG_STATE:  o_prdata[31:28] <= chan_r.chan_state; // [RULE8]
                DMAEDS_OFS_DBG_SRC:    o_prdata        <= chan_r.src_addr;   // [RULE9]
                DMAEDS_OFS_DBG_TRG:    o_prdata        <= chan_r.trg_addr;   // [RULE10]
                DMAEDS_OFS_DBG_CFG: begin
                    o_prdata[31]    <= chan_r.chan_en;    // [RULE11]
                    o_prdata[30]    <= chan_r.inc_src;    // [RULE11]
                    o_prdata[29]    <= chan_r.inc_trg;    // [RULE11]
                    o_prdata[28:16] <= chan_r.ctrl_len;   // [RULE12]
                    o_prdata[15:14] <= chan_r.burst_size; // [RULE12] [RULE17]
                    o_prdata[13:12] <= chan_r.tran_type;  // [RULE12] [RULE16]
                    o_prdata[11:10] <= chan_r.item_width; // [RULE12]
                end
                DMAEDS_OFS_DBG_DPATH: begin
                    o_prdata[31]    <= dpath_r.mas_read;   // [RULE13]
                    o_prdata[30]    <= dpath_r.mas_write;
                    o_prdata[29:28] <= dpath_r.size;
                    o_prdata[27:26] <= dpath_r.burst;
                    o_prdata[25:19] <= dpath_r.slice_cnt;
                    o_prdata[18]    <= dpath_r.split_word;
                    o_prdata[17]    <= dpath_r.split_half;
                end
                DMAEDS_OFS_DBG_MASTER: begin
                    o_prdata[31:29] <= ahb_r.hburst; // [RULE14]
                    o_prdata[28:27] <= ahb_r.htrans;
                    o_prdata[26:24] <= ahb_r.hsize;
                    o_prdata[23]    <= ahb_r.hready;
                    o_prdata[22]    <= ahb_r.hresp[0];
                end
                DMAEDS_OFS_IRQ_STATUS: o_prdata[DMAEDS_IRQ_W-1:0] <= irq_stat_r;
                DMAEDS_OFS_IRQ_MASK:   o_prdata[DMAEDS_IRQ_W-1:0] <= irq_mask_r;
                default:               o_prdata <= '0;
            endcase
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_ack_start;
        ack_state_r == ACK_IDLE && i_periph_wr_req && ack_delay_r == DMAEDS_DELAY_RST;
    endsequence

    sequence s_ack_zero;
        ack_state_r == ACK_IDLE && i_periph_wr_req && ack_delay_r == '0;
    endsequence

    // Thirteen quiet cycles, request edge included
    sequence s_ack_quiet;
        !o_periph_wr_ack [*8] ##1 !o_periph_wr_ack [*5];
    endsequence

    sequence s_rd(logic [11:0] ofs);
        rd_en && i_paddr == ofs;
    endsequence

    a_ack_delay_twelve: assert property ( // [RULE1]
        s_ack_start |-> s_ack_quiet ##1 o_periph_wr_ack)
        else $error("ack not after twelve cycles");
    a_ack_no_delay: assert property ( // [RULE1]
        s_ack_zero |=> o_periph_wr_ack)
        else $error("ack not immediate for zero delay");
    a_ack_pulse: assert property ( // [RULE1]
        o_periph_wr_ack |=> !o_periph_wr_ack)
        else $error("ack longer than one cycle");
    a_ack_refuse: assert property ( // [RULE1]
        o_ack_busy && !o_periph_wr_ack |=> o_ack_busy)
        else $error("delay cut short");
    a_delay_write: assert property ( // [RULE1]
        wr_en && i_paddr == DMAEDS_OFS_ACK_DELAY
        |=> ack_delay_r == $past(i_pwdata[DMAEDS_DELAY_W-1:0]))
        else $error("delay write lost");
    a_delay_read: assert property ( // [RULE1]
        s_rd(DMAEDS_OFS_ACK_DELAY) |=> o_prdata[DMAEDS_DELAY_W-1:0] == $past(ack_delay_r)
        && o_prdata[31:DMAEDS_DELAY_W] == '0)
        else $error("delay read wrong");
    a_err_capture: assert property ( // [RULE2]
        bus_err |=> err_addr_r == $past(ahb_r.haddr))
        else $error("error address not captured");
    a_err_chan_pair: assert property ( // [RULE3]
        bus_err |=> err_chan_r == $past(chan_r.chan_num))
        else $error("error channel not captured");
    a_err_hold: assert property ( // [RULE18]
        !bus_err |=> $stable(err_addr_r) && $stable(err_chan_r))
        else $error("error registers changed without error");
    a_erraddr_read: assert property ( // [RULE2]
        s_rd(DMAEDS_OFS_ERR_ADDR) |=> o_prdata == $past(err_addr_r))
        else $error("error address read wrong");
    a_errchan_read: assert property ( // [RULE3]
        s_rd(DMAEDS_OFS_ERR_CHAN) |=> o_prdata == {$past(err_chan_r), 27'h0})
        else $error("error channel read wrong");
    a_snap_follow: assert property ( // [RULE19]
        1'b1 |=> chan_r == $past(i_chan))
        else $error("snapshot not live");
    a_dpath_follow: assert property ( // [RULE13]
        1'b1 |=> dpath_r == $past(i_dpath))
        else $error("datapath snapshot not live");
    a_ahb_follow: assert property ( // [RULE14]
        1'b1 |=> ahb_r == $past(i_ahb))
        else $error("master snapshot not live");
    a_dbgaddr_read: assert property ( // [RULE4]
        s_rd(DMAEDS_OFS_DBG_ADDR) |=> o_prdata == $past(chan_r.diag_addr))
        else $error("debug address read wrong");
    a_reqlen_read: assert property ( // [RULE5] [RULE6] [RULE7]
        s_rd(DMAEDS_OFS_DBG_REQLEN) |=> o_prdata[31] == $past(chan_r.req_valid)
        && o_prdata[30:18] == $past(chan_r.rest_len) && o_prdata[4:0] == $past(chan_r.chan_num))
        else $error("request register read wrong");
    a_state_read: assert property ( // [RULE8]
        s_rd(DMAEDS_OFS_DBG_STATE) |=> o_prdata == {$past(chan_r.chan_state), 28'h0})
        else $error("state register read wrong");
    a_src_read: assert property ( // [RULE9]
        s_rd(DMAEDS_OFS_DBG_SRC) |=> o_prdata == $past(chan_r.src_addr))
        else $error("source address read wrong");
    a_trg_read: assert property ( // [RULE10]
        s_rd(DMAEDS_OFS_DBG_TRG) |=> o_prdata == $past(chan_r.trg_addr))
        else $error("target address read wrong");
    a_cfg_read: assert property ( // [RULE11] [RULE12]
        s_rd(DMAEDS_OFS_DBG_CFG) |=> o_prdata[11:10] == $past(chan_r.item_width)
        && o_prdata[31] == $past(chan_r.chan_en) && o_prdata[29] == $past(chan_r.inc_trg)
        && o_prdata[28:16] == $past(chan_r.ctrl_len) && o_prdata[9:0] == 10'h000)
        else $error("config register read wrong");
    a_cfg_codes: assert property ( // [RULE16] [RULE17]
        s_rd(DMAEDS_OFS_DBG_CFG) |=> o_prdata[15:14] == $past(chan_r.burst_size)
        && o_prdata[13:12] == $past(chan_r.tran_type))
        else $error("config codes read wrong");
    a_dpath_read: assert property ( // [RULE13]
        s_rd(DMAEDS_OFS_DBG_DPATH) |=> o_prdata[25:19] == $past(dpath_r.slice_cnt)
        && o_prdata[31] == $past(dpath_r.mas_read) && o_prdata[16:0] == 17'h0)
        else $error("datapath register read wrong");
    a_master_read: assert property ( // [RULE14]
        s_rd(DMAEDS_OFS_DBG_MASTER) |=> o_prdata[23] == $past(ahb_r.hready)
        && o_prdata[31:29] == $past(ahb_r.hburst) && o_prdata[21:0] == 22'h0)
        else $error("master register read wrong");
    a_burst_items: assert property ( // [RULE17]
        $past(chan_r.burst_size) == 2'h3 |-> o_burst_items == 5'h10)
        else $error("burst items wrong");
    a_burst_one: assert property ( // [RULE17]
        $past(chan_r.burst_size) == 2'h0 |-> o_burst_items == 5'h01)
        else $error("single burst items wrong");

endmodule

/* bench/dmaeds_far_model.sv */
// Far-side model: bus master signals, bus error injection, peripheral write requester
`timescale 1ns/1ps
module dmaeds_far_model
    import dmaeds_pkg::*;
(
    input  wire logic           i_ref_clk,
    input  wire logic           i_reset_n,
    input  wire dmaeds_ahb_type i_ahb_set,
    input  wire logic           i_start,
    input  wire logic           i_fault,
    input  wire logic           i_ack,
    output dmaeds_ahb_type      o_ahb,
    output logic                o_req,
    output logic [10:0]         o_lat,
    output logic [7:0]          o_n_ack
);
    logic        wait_r;
    logic [10:0] cnt_r;

    assign o_req = i_start;

    // Fault cycle: nonsequential transfer answered with an error response
    always_comb begin
        o_ahb = i_ahb_set;
        if (i_fault) begin
            o_ahb.htrans = 2'h2;
            o_ahb.hresp  = DMAEDS_HRESP_ERROR;
        end
    end

    // Wait cycles between accepted request and acknowledge
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wait_r  <= 1'b0;
            cnt_r   <= 11'h000;
            o_lat   <= 11'h000;
            o_n_ack <= 8'h00;
        end else if (i_ack) begin
            wait_r  <= 1'b0;
            o_lat   <= cnt_r;
            o_n_ack <= o_n_ack + 8'h01;
        end else if (wait_r) begin
            cnt_r <= cnt_r + 11'h001;
        end else if (o_req) begin
            wait_r <= 1'b1;
            cnt_r  <= 11'h000;
        end
    end
endmodule

/* bench/testbench.sv */
// Testbench: register access, acknowledge delay, snapshots, error capture, interrupt
`timescale 1ns/1ps
module testbench;
    import dmaeds_pkg::*;
    logic             clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic             start, fault, req, ack, busy, irq, se;
    logic [11:0]      paddr;
    logic [31:0]      pwdata, prdata, r;
    logic [4:0]       items;
    logic [10:0]      lat;
    logic [7:0]       n_ack;
    dmaeds_chan_type  chan;
    dmaeds_dpath_type dpath;
    dmaeds_ahb_type   ahb_set, ahb;
    int               n_mismatch = 0;
    int               num_checks = 0;
    logic [4:0]       bi [4] = '{5'h01, 5'h04, 5'h08, 5'h10};
    logic [11:0]      ofs [11] = '{DMAEDS_OFS_ACK_DELAY, DMAEDS_OFS_ERR_ADDR, DMAEDS_OFS_ERR_CHAN,
        DMAEDS_OFS_DBG_ADDR, DMAEDS_OFS_DBG_REQLEN, DMAEDS_OFS_DBG_STATE, DMAEDS_OFS_DBG_SRC,
        DMAEDS_OFS_DBG_TRG, DMAEDS_OFS_DBG_CFG, DMAEDS_OFS_DBG_DPATH, DMAEDS_OFS_DBG_MASTER};
    // Defined bits only, reserved read bits ignored
    logic [31:0]      msk [11] = '{32'h0000_03ff, 32'hffff_ffff, 32'hf800_0000, 32'hffff_ffff,
        32'hfffc_001f, 32'hf000_0000, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_fc00,
        32'hfffe_0000, 32'hffc0_0000};

    dmaeds_top uut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_chan(chan), .i_dpath(dpath), .i_ahb(ahb),
        .i_periph_wr_req(req), .o_periph_wr_ack(ack), .o_ack_busy(busy),
        .o_burst_items(items), .o_irq(irq));
    dmaeds_far_model far (.i_ref_clk(clk), .i_reset_n(rst_n), .i_ahb_set(ahb_set),
        .i_start(start), .i_fault(fault), .i_ack(ack), .o_ahb(ahb), .o_req(req),
        .o_lat(lat), .o_n_ack(n_ack));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One APB transfer; read data and error taken at the completing edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_mismatch++;
            report_and_stop();
        end
        r = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic t_reset();
        for (int k = 0; k < 11; k++) begin
            apb(1'b0, ofs[k], 32'h0);
            chk("reset value", r & msk[k], (k == 0) ? 32'h0000_000c : 32'h0);
        end
        apb(1'b1, DMAEDS_OFS_ERR_ADDR, 32'hffff_ffff);
        apb(1'b0, DMAEDS_OFS_ERR_ADDR, 32'h0);
        chk("read-only error address", r, 32'h0);
        apb(1'b0, 12'h0a8, 32'h0);
        chk("unmapped error", {31'h0, se}, 32'h1);
    endtask

    task automatic t_ack();
        logic [9:0] d [5] = '{10'h000, 10'h001, 10'h005, 10'h00c, 10'h3ff};
        logic [7:0] n0;
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, DMAEDS_OFS_ACK_DELAY, {22'h0, d[i]});
            apb(1'b0, DMAEDS_OFS_ACK_DELAY, 32'h0);
            chk("delay field", r & 32'h3ff, {22'h0, d[i]});
            n0 = n_ack;
            @(posedge clk);
            start <= 1'b1;
            // Third case keeps requesting while busy
            repeat ((i == 2) ? 3 : 1) @(posedge clk);
            start <= 1'b0;
            for (int k = 0; k < 1100 && n_ack == n0; k++)
                @(posedge clk);
            if (n_ack == n0) begin
                n_mismatch++;
                report_and_stop();
            end
            tick(4);
            chk("ack count", {24'h0, n_ack}, {24'h0, n0 + 8'h01});
            chk("ack latency", {21'h0, lat}, {21'h0, 1'b0, d[i]});
            chk("busy after ack", {31'h0, busy}, 32'h0);
        end
        apb(1'b0, DMAEDS_OFS_IRQ_STATUS, 32'h0);
        chk("ack done status", r & 32'h2, 32'h2);
    endtask

    task automatic t_snap();
        logic [159:0]     big;
        dmaeds_chan_type  c;
        dmaeds_dpath_type p;
        dmaeds_ahb_type   a;
        logic [31:0]      e [8];
        for (int i = 0; i < 4; i++) begin
            big = {5{32'h5a3c_96e1 ^ (32'h3377_1155 * i)}};
            c = dmaeds_chan_type'(big[$bits(dmaeds_chan_type)-1:0]);
            p = dmaeds_dpath_type'(big[$bits(dmaeds_dpath_type)+2:3]);
            a = dmaeds_ahb_type'(big[$bits(dmaeds_ahb_type)+6:7]);
            c.burst_size = i[1:0];
            c.tran_type = 2'(i % 3);
            chan <= c;
            dpath <= p;
            ahb_set <= a;
            tick(3);
            chk("burst items", {27'h0, items}, {27'h0, bi[i]});
            e = '{c.diag_addr, {c.req_valid, c.rest_len, 13'h0, c.chan_num},
                {c.chan_state, 28'h0}, c.src_addr, c.trg_addr,
                {c.chan_en, c.inc_src, c.inc_trg, c.ctrl_len, c.burst_size,
                c.tran_type, c.item_width, 10'h0},
                {p.mas_read, p.mas_write, p.size, p.burst, p.slice_cnt,
                p.split_word, p.split_half, 17'h0},
                {a.hburst, a.htrans, a.hsize, a.hready, a.hresp[0], 22'h0}};
            for (int k = 0; k < 8; k++) begin
                apb(1'b0, ofs[k+3], 32'h0);
                chk("snapshot", r & msk[k+3], e[k] & msk[k+3]);
            end
        end
    endtask

    task automatic t_err();
        logic [31:0] ad [2] = '{32'h1234_5678, 32'h8765_4320};
        logic [4:0]  ch [2] = '{5'h13, 5'h07};
        ahb_set <= '0;
        apb(1'b1, DMAEDS_OFS_IRQ_MASK, 32'h0);
        apb(1'b1, DMAEDS_OFS_IRQ_STATUS, 32'h3);
        for (int i = 0; i < 2; i++) begin
            chan.chan_num <= ch[i];
            ahb_set.haddr <= ad[i];
            tick(3);
            apb(1'b0, DMAEDS_OFS_ERR_ADDR, 32'h0);
            chk("held error address", r, (i == 0) ? 32'h0 : ad[0]);
            fault <= 1'b1;
            @(posedge clk);
            fault <= 1'b0;
            tick(3);
            apb(1'b0, DMAEDS_OFS_ERR_ADDR, 32'h0);
            chk("error address", r, ad[i]);
            apb(1'b0, DMAEDS_OFS_ERR_CHAN, 32'h0);
            chk("error channel", r & 32'hf800_0000, {ch[i], 27'h0});
        end
        apb(1'b0, DMAEDS_OFS_IRQ_STATUS, 32'h0);
        chk("error status", r & 32'h1, 32'h1);
        chk("masked irq", {31'h0, irq}, 32'h0);
        apb(1'b1, DMAEDS_OFS_IRQ_MASK, 32'h1);
        tick(1);
        chk("unmasked irq", {31'h0, irq}, 32'h1);
        apb(1'b1, DMAEDS_OFS_IRQ_STATUS, 32'h1);
        tick(1);
        chk("cleared irq", {31'h0, irq}, 32'h0);
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        start = 1'b0;
        fault = 1'b0;
        chan = '0;
        dpath = '0;
        ahb_set = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_ack();
        t_snap();
        t_err();
        report_and_stop();
    end
endmodule
